//--- core/bfp_core.sv
// Breaker-failure pickup, blocking, delay timers and register port
//
// Behaviour
// - Current pick-up when any one, two or three phases exceed threshold.
// - Release only below 97 % of the threshold setting.
// - One phase threshold shared by all three phases.
// - Residual source: 0 unused, 1 first, 2 second, 3 calculated.
// - Mode codes 0..10 select current, output, signal combinations.
// - Phase threshold in 0.01 x In steps, default 0.20.
// - Residual threshold in 0.001 x In steps, default 1.200.
// - Start only on pick-up while blocking is inactive.
// - Signal criterion picks up in the same evaluation, no delay.
// - Blocking input sampled at every program cycle start.
// - Blocked pick-up raises blocked, starts no timer.
// - Blocking during start drops start and resets timers.
// - Blocking issues an event with currents and fault type.
// - Retrip and breaker-failure timers start from the same pick-up.
// - Retrip enable, default yes; disabled means no retrip output.
// - Retrip after start persists retrip delay; 5 ms steps, 0.100 s.
// - Breaker failure after its delay; default 0.200 s.
// - Condition code: 0 normal, 1 start, 2 retrip, 3 failure, 4 blocked.
// - Behaviour code: 1 on, 2 blocked, 3 test, 4 test/blocked, 5 off.
// - With forcing enabled a software switch drives blocking.
// - Current-only: timers clear once current falls below 97 % of threshold.
// - Inputs refreshed on the 5 ms time base.
// - Forcing imposes status 0..4 from the force select.
`timescale 1ns/1ps
module bfp_core #(
  parameter int unsigned TICK_CYCLES = bfp_pkg::TICK_CYCLES
) (
  input  wire  logic                       sys_clk,
  input  wire  logic                       rst_b,
  input  wire  logic [bfp_pkg::ADDR_W-1:0] reg_addr,
  input  wire  logic [31:0]                reg_wdata,
  input  wire  logic                       reg_wr,
  input  wire  logic                       reg_rd,
  output logic       [31:0]                reg_rdata,
  input  wire  bfp_pkg::bfp_meas_type      meas,
  input  wire  logic                       do_monitor,
  input  wire  logic                       signal_monitor,
  input  wire  logic                       block_in,
  output logic                             start_out,
  output logic                             retrip_out,
  output logic                             breaker_failure_output,
  output logic                             blocked_out,
  output logic       [2:0]                 condition_code,
  output logic       [2:0]                 behaviour_code,
  output bfp_pkg::bfp_event_type           event_out
);
  import bfp_pkg::*;

  // Mode decoding, used by the pick-up evaluation
  function automatic logic mode_eval(input logic [3:0] m, input logic c,
                                     input logic d, input logic s);
    logic r;
    r = 1'b0;
    case (m)
      MODE_CUR:          r = c;
      MODE_DO:           r = d;
      MODE_SIG:          r = s;
      MODE_CUR_AND_DO:   r = c & d;
      MODE_CUR_OR_DO:    r = c | d;
      MODE_CUR_AND_SIG:  r = c & s;
      MODE_CUR_OR_SIG:   r = c | s;
      MODE_SIG_AND_DO:   r = s & d;
      MODE_SIG_OR_DO:    r = s | d;
      MODE_CUR_OR_SIG_B: r = c | s;
      MODE_ALL_AND:      r = c & d & s;
      default:           r = 1'b0;
    endcase
    return r;
  endfunction

  // Register state
  logic [15:0]      ctrl_reg;
  logic [MAG_W-1:0] phase_thr_reg;
  logic [MAG_W-1:0] resid_thr_reg;
  logic [DLY_W-1:0] retrip_dly_reg;
  logic [DLY_W-1:0] bf_dly_reg;
  logic [TICK_W-1:0] tick_cnt_reg;
  logic             tick_reg;
  logic [3:0]       pick_reg;
  logic [DLY_W-1:0] timer_reg;
  logic             start_reg;
  logic             retrip_reg;
  logic             bf_reg;
  logic             blocked_reg;

  // Control fields
  wire logic [3:0] mode_sel      = ctrl_reg[MODE_LSB +: 4];
  wire logic [1:0] residual_source_select = ctrl_reg[RSEL_LSB +: 2];
  wire logic       retrip_en     = ctrl_reg[RETRIP_BIT];
  wire logic       force_en      = ctrl_reg[FORCE_BIT];
  wire logic [2:0] forced_status_select = ctrl_reg[FSTAT_LSB +: 3];
  wire logic       sw_block      = ctrl_reg[SWBLK_BIT];
  wire logic [2:0] behav_set     = ctrl_reg[BEHAV_LSB +: 3];

  // Program-cycle tick divider; long count shortened by the parameter
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);
  wire logic tick_wrap = (tick_cnt_reg == TICK_LAST);
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      tick_cnt_reg <= '0;
      tick_reg     <= 1'b0;
    end else begin
      tick_cnt_reg <= tick_wrap ? '0 : tick_cnt_reg + 1'b1;
      tick_reg     <= tick_wrap;
    end
  end

  // Channel magnitudes and thresholds in 0.001 x In
  wire logic [MAG_W-1:0] phase_thr_milli =
    MAG_W'(phase_thr_reg * PHASE_SCALE);
  logic [MAG_W-1:0] resid_mag;
  always_comb begin
    case (residual_source_select)
      RSEL_FIRST: resid_mag = meas.first_residual_input;
      RSEL_SECND: resid_mag = meas.second_residual_input;
      RSEL_CALC:  resid_mag = meas.calculated_residual;
      default:    resid_mag = '0;
    endcase
  end
  wire logic [MAG_W-1:0] measured_magnitude [4] = '{
    meas.phase1, meas.phase2, meas.phase3, resid_mag};
  wire logic [MAG_W-1:0] ch_thr [4] = '{
    phase_thr_milli, phase_thr_milli, phase_thr_milli,
    resid_thr_reg};
  wire logic [3:0] ch_enable = {residual_source_select != RSEL_NONE,
                                3'b111};

  // Comparator with 97 % hysteresis per channel
  logic [3:0] pick_next;
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_chan
      // Widen before multiplying so large currents do not wrap
      wire logic [23:0] mag_pct = 24'(measured_magnitude[g]) * 24'(PCT_FULL);
      wire logic [23:0] rel_pct = 24'(ch_thr[g]) * 24'(PCT_RESET);
      wire logic above = measured_magnitude[g] > ch_thr[g];
      wire logic below = mag_pct < rel_pct;
      assign pick_next[g] = ch_enable[g] &
                            (pick_reg[g] ? !below : above);
    end
  endgenerate

  // Criteria and mode combination, all from this evaluation's inputs
  wire logic crit_cur  = |pick_next;
  wire logic pickup    = mode_eval(mode_sel, crit_cur, do_monitor,
                                   signal_monitor);
  wire logic beh_block = (behav_set == BEH_BLOCKED) ||
                         (behav_set == BEH_TEST_BLK);
  wire logic beh_off   = (behav_set == BEH_OFF);
  // Software switch replaces the matrix input during commissioning
  wire logic block_eff = (force_en ? sw_block : block_in) | beh_block;
  wire logic start_now = pickup & !block_eff & !beh_off;
  wire logic blk_now   = pickup &  block_eff & !beh_off;
  // One counter times both delays since they share a start
  wire logic [DLY_W-1:0] timer_next =
    start_now ? ((&timer_reg) ? timer_reg : timer_reg + 1'b1) : '0;

  // Evaluation at each program-cycle tick
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      pick_reg    <= '0;
      timer_reg   <= '0;
      start_reg   <= 1'b0;
      retrip_reg  <= 1'b0;
      bf_reg      <= 1'b0;
      blocked_reg <= 1'b0;
    end else if (tick_reg) begin
      pick_reg    <= pick_next;
      timer_reg   <= timer_next;
      start_reg   <= start_now;
      // Elapsed ticks before this one, so a delay of D fires D ticks after start
      retrip_reg  <= start_now & retrip_en &
                     (timer_reg >= retrip_dly_reg);
      bf_reg      <= start_now & (timer_reg >= bf_dly_reg);
      blocked_reg <= blk_now;
    end
  end

  // Forced status overrides the live result while forcing is enabled
  wire logic f_start = (forced_status_select == COND_START) ||
                       (forced_status_select == COND_RETRIP) ||
                       (forced_status_select == COND_BF);
  wire logic st_o  = force_en ? f_start : start_reg;
  wire logic rt_o  = force_en ? (forced_status_select == COND_RETRIP)
                              : retrip_reg;
  wire logic bf_o  = force_en ? (forced_status_select == COND_BF)
                              : bf_reg;
  wire logic bl_o  = force_en ? (forced_status_select == COND_BLOCKED)
                              : blocked_reg;
  wire logic [2:0] cond_next = bl_o ? COND_BLOCKED :
                               bf_o ? COND_BF :
                               rt_o ? COND_RETRIP :
                               st_o ? COND_START : COND_NORMAL;
  wire logic test_mode = (behav_set == BEH_TEST) ||
                         (behav_set == BEH_TEST_BLK);
  // Behaviour reported: test and blocking are folded together
  wire logic [2:0] behav_next =
    beh_off ? BEH_OFF :
    test_mode ? (block_eff ? BEH_TEST_BLK : BEH_TEST) :
    (block_eff ? BEH_BLOCKED : BEH_ON);

  // Event on each rising start or blocked indication
  wire logic blk_rise   = blk_now & !blocked_reg;
  wire logic start_rise = start_now & !start_reg;

  // Outputs all leave from flip-flops
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      start_out              <= 1'b0;
      retrip_out             <= 1'b0;
      breaker_failure_output <= 1'b0;
      blocked_out            <= 1'b0;
      condition_code         <= COND_NORMAL;
      behaviour_code         <= BEH_ON;
    end else begin
      start_out              <= st_o;
      retrip_out             <= rt_o & retrip_en;
      breaker_failure_output <= bf_o;
      blocked_out            <= bl_o;
      condition_code         <= cond_next;
      behaviour_code         <= behav_next;
    end
  end

  // Event record carries startup currents and faulted channels
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      event_out <= '0;
    end else begin
      event_out.valid <= tick_reg & (blk_rise | start_rise);
      if (tick_reg & (blk_rise | start_rise)) begin
        event_out.is_block   <= blk_rise;
        event_out.fault_type <= pick_next;
        event_out.phase1     <= meas.phase1;
        event_out.phase2     <= meas.phase2;
        event_out.phase3     <= meas.phase3;
      end
    end
  end

  // Register writes; thresholds and delays steer the evaluation
  wire logic [15:0] ctrl_rst = {1'b0, BEHAV_RST, 4'h0, 1'b0,
                                RETRIP_EN_RST, RSEL_RST, MODE_RST};
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      ctrl_reg       <= ctrl_rst;
      phase_thr_reg  <= PHASE_THR_RST;
      resid_thr_reg  <= RESID_THR_RST;
      retrip_dly_reg <= RETRIP_DLY_RST;
      bf_dly_reg     <= BF_DLY_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        CTRL_ADDR:       ctrl_reg       <= reg_wdata[15:0];
        PHASE_THR_ADDR:  phase_thr_reg  <= reg_wdata[MAG_W-1:0];
        RESID_THR_ADDR:  resid_thr_reg  <= reg_wdata[MAG_W-1:0];
        RETRIP_DLY_ADDR: retrip_dly_reg <= reg_wdata[DLY_W-1:0];
        BF_DLY_ADDR:     bf_dly_reg     <= reg_wdata[DLY_W-1:0];
        default:         ;
      endcase
    end
  end

  // Read decode; unmapped addresses read zero
  logic [31:0] rdata_next;
  always_comb begin
    case (reg_addr)
      CTRL_ADDR:       rdata_next = {16'h0000, ctrl_reg};
      PHASE_THR_ADDR:  rdata_next = {16'h0000, phase_thr_reg};
      RESID_THR_ADDR:  rdata_next = {16'h0000, resid_thr_reg};
      RETRIP_DLY_ADDR: rdata_next = {13'h0000, retrip_dly_reg};
      BF_DLY_ADDR:     rdata_next = {13'h0000, bf_dly_reg};
      STATUS_ADDR:     rdata_next = {16'h0000, pick_reg, 1'b0,
                                     behaviour_code, 1'b0, condition_code,
                                     blocked_out, breaker_failure_output,
                                     retrip_out, start_out};
      default:         rdata_next = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= reg_rd ? rdata_next : '0;
    end
  end

  // Checks on the evaluation and the outputs
  property p_start_needs_free;
    @(posedge sys_clk) disable iff (!rst_b)
      tick_reg && pickup && block_eff |=> !start_reg && !(|timer_reg);
  endproperty
  a_start_needs_free: assert property (p_start_needs_free)
    else $error("start or timer with blocking active");

  property p_block_drop;
    @(posedge sys_clk) disable iff (!rst_b)
      start_reg && tick_reg && block_eff |=> !start_reg && !retrip_reg;
  endproperty
  a_block_drop: assert property (p_block_drop)
    else $error("start survived blocking");

  property p_signal_immediate;
    @(posedge sys_clk) disable iff (!rst_b)
      tick_reg && mode_sel == MODE_SIG && signal_monitor && !block_eff &&
      !beh_off |=> start_reg;
  endproperty
  a_signal_immediate: assert property (p_signal_immediate)
    else $error("signal pick-up delayed");

  property p_retrip_timing;
    @(posedge sys_clk) disable iff (!rst_b)
      $rose(retrip_reg) |-> $past(timer_reg) >= $past(retrip_dly_reg) &&
        start_reg;
  endproperty
  a_retrip_timing: assert property (p_retrip_timing)
    else $error("retrip before its delay");

  property p_bf_timing;
    @(posedge sys_clk) disable iff (!rst_b)
      $rose(bf_reg) |-> $past(timer_reg) >= $past(bf_dly_reg) &&
        start_reg;
  endproperty
  a_bf_timing: assert property (p_bf_timing)
    else $error("breaker failure before its delay");

  property p_retrip_off;
    @(posedge sys_clk) disable iff (!rst_b)
      !retrip_en |=> !retrip_out;
  endproperty
  a_retrip_off: assert property (p_retrip_off)
    else $error("retrip output while disabled");

  property p_timer_reload;
    @(posedge sys_clk) disable iff (!rst_b)
      tick_reg && !start_now |=> timer_reg == '0 ##1 !bf_reg;
  endproperty
  a_timer_reload: assert property (p_timer_reload)
    else $error("timer kept count after condition dropped");

  property p_cond_code;
    @(posedge sys_clk) disable iff (!rst_b)
      !force_en && $past(!force_en) && blocked_reg
        |=> condition_code == COND_BLOCKED;
  endproperty
  a_cond_code: assert property (p_cond_code)
    else $error("blocked not reported in condition code");

  property p_force_status;
    @(posedge sys_clk) disable iff (!rst_b)
      force_en && forced_status_select == COND_BF
        |=> breaker_failure_output && start_out;
  endproperty
  a_force_status: assert property (p_force_status)
    else $error("forced failure status not shown");

  property p_tick_period;
    @(posedge sys_clk) disable iff (!rst_b)
      tick_reg |=> !tick_reg;
  endproperty
  a_tick_period: assert property (p_tick_period)
    else $error("program tick longer than one cycle");

  c_retrip: cover property (@(posedge sys_clk) disable iff (!rst_b)
    $rose(retrip_out));
  c_bf: cover property (@(posedge sys_clk) disable iff (!rst_b)
    $rose(breaker_failure_output));
  c_blocked_event: cover property (@(posedge sys_clk) disable iff (!rst_b)
    event_out.valid && event_out.is_block);
  c_block_during_start: cover property (@(posedge sys_clk)
    disable iff (!rst_b) start_reg ##1 tick_reg && block_eff);

endmodule

//--- common/bfp_pkg.sv
// Constants and carrier types for the breaker-failure pickup timing block
package bfp_pkg;

  // Timing: program cycle of 5 ms on a 4 ns system clock
  localparam int unsigned CLK_PERIOD_PS  = 4000;
  localparam int unsigned PROG_CYCLE_MS  = 5;
  // Divide first: the plain product would overflow 32 bits
  localparam int unsigned TICK_CYCLES    =
    PROG_CYCLE_MS * (1000000000 / CLK_PERIOD_PS);
  localparam int unsigned TICK_W         = 21;

  // Widths
  localparam int unsigned MAG_W  = 16;  // Magnitudes in 0.001 x In
  localparam int unsigned DLY_W  = 19;  // Delays in 5 ms steps
  localparam int unsigned ADDR_W = 8;

  // Register byte addresses
  localparam logic [7:0] CTRL_ADDR       = 8'h00;
  localparam logic [7:0] PHASE_THR_ADDR  = 8'h04;
  localparam logic [7:0] RESID_THR_ADDR  = 8'h08;
  localparam logic [7:0] RETRIP_DLY_ADDR = 8'h0C;
  localparam logic [7:0] BF_DLY_ADDR     = 8'h10;
  localparam logic [7:0] STATUS_ADDR     = 8'h14;

  // Control field positions
  localparam int unsigned MODE_LSB    = 0;   // 4 bits
  localparam int unsigned RSEL_LSB    = 4;   // 2 bits
  localparam int unsigned RETRIP_BIT  = 6;
  localparam int unsigned FORCE_BIT   = 7;
  localparam int unsigned FSTAT_LSB   = 8;   // 3 bits
  localparam int unsigned SWBLK_BIT   = 11;
  localparam int unsigned BEHAV_LSB   = 12;  // 3 bits

  // Reset values
  localparam logic [3:0]       MODE_RST       = 4'h0;
  localparam logic [1:0]       RSEL_RST       = 2'h0;
  localparam logic             RETRIP_EN_RST  = 1'b1;
  localparam logic [2:0]       BEHAV_RST      = 3'h1;
  localparam logic [MAG_W-1:0] PHASE_THR_RST  = 16'h0014; // 0.20 in 0.01
  localparam logic [MAG_W-1:0] RESID_THR_RST  = 16'h04B0; // 1.200 in 0.001
  localparam logic [DLY_W-1:0] RETRIP_DLY_RST = 19'h00014; // 0.100 s
  localparam logic [DLY_W-1:0] BF_DLY_RST     = 19'h00028; // 0.200 s

  // Threshold arithmetic: phase step is ten residual steps, 97 % reset
  localparam logic [7:0] PHASE_SCALE = 8'h0A;
  localparam logic [7:0] PCT_FULL    = 8'h64;
  localparam logic [7:0] PCT_RESET   = 8'h61;

  // Residual source codes
  localparam logic [1:0] RSEL_NONE  = 2'h0;
  localparam logic [1:0] RSEL_FIRST = 2'h1;
  localparam logic [1:0] RSEL_SECND = 2'h2;
  localparam logic [1:0] RSEL_CALC  = 2'h3;

  // Condition codes
  localparam logic [2:0] COND_NORMAL  = 3'h0;
  localparam logic [2:0] COND_START   = 3'h1;
  localparam logic [2:0] COND_RETRIP  = 3'h2;
  localparam logic [2:0] COND_BF      = 3'h3;
  localparam logic [2:0] COND_BLOCKED = 3'h4;

  // Behaviour codes
  localparam logic [2:0] BEH_ON       = 3'h1;
  localparam logic [2:0] BEH_BLOCKED  = 3'h2;
  localparam logic [2:0] BEH_TEST     = 3'h3;
  localparam logic [2:0] BEH_TEST_BLK = 3'h4;
  localparam logic [2:0] BEH_OFF      = 3'h5;

  typedef enum logic [3:0] {
    MODE_CUR, MODE_DO, MODE_SIG, MODE_CUR_AND_DO, MODE_CUR_OR_DO,
    MODE_CUR_AND_SIG, MODE_CUR_OR_SIG, MODE_SIG_AND_DO, MODE_SIG_OR_DO,
    MODE_CUR_OR_SIG_B, MODE_ALL_AND
  } bfp_mode_type;

  // Measurement inputs, refreshed every program cycle
  typedef struct packed {
    logic [MAG_W-1:0] phase1;
    logic [MAG_W-1:0] phase2;
    logic [MAG_W-1:0] phase3;
    logic [MAG_W-1:0] first_residual_input;
    logic [MAG_W-1:0] second_residual_input;
    logic [MAG_W-1:0] calculated_residual;
  } bfp_meas_type;

  // Event record: blocking or start, with fault type and currents
  typedef struct packed {
    logic             valid;
    logic             is_block;
    logic [3:0]       fault_type;   // Bit 3 residual, bits 2..0 phases
    logic [MAG_W-1:0] phase1;
    logic [MAG_W-1:0] phase2;
    logic [MAG_W-1:0] phase3;
  } bfp_event_type;

endpackage

//--- dv/bfp_feed.sv
// Far-side model: measurement channels, monitors and blocking matrix
`timescale 1ns/1ps
module bfp_feed
  import bfp_pkg::*;
(
  input  wire logic         sys_clk,
  input  wire bfp_meas_type cmd_meas,
  input  wire logic         cmd_do,
  input  wire logic         cmd_sig,
  input  wire logic         cmd_blk,
  output bfp_meas_type      meas,
  output logic              do_monitor,
  output logic              signal_monitor,
  output logic              block_in
);
  // Refresh every clock, far inside one program cycle
  always_ff @(posedge sys_clk) begin
    meas           <= cmd_meas;
    do_monitor     <= cmd_do;
    signal_monitor <= cmd_sig;
    block_in       <= cmd_blk;
  end
endmodule

//--- dv/bfp_core_tb_top.sv
// Self-checking bench for the breaker-failure pickup core
`timescale 1ns/1ps
module bfp_core_tb_top;
  import bfp_pkg::*;
  localparam int TK = 10;
  logic          sys_clk, rst_b, reg_wr, reg_rd, rd_d;
  logic          do_c, sig_c, blk_c, do_m, sig_m, blk_m, cc, cd, cs, ex;
  logic [7:0]    reg_addr;
  logic [31:0]   reg_wdata, reg_rdata;
  logic [31:0]   exp_q[$], msk_q[$];
  bfp_meas_type  meas, m_c;
  logic          start_out, retrip_out, bf_out, blocked_out;
  logic [2:0]    condition_code, behaviour_code;
  bfp_event_type event_out, last_ev;
  int            fail_count, samples_checked, cyc, k;
  integer        seed;

  bfp_feed u_feed (.sys_clk(sys_clk), .cmd_meas(m_c), .cmd_do(do_c),
    .cmd_sig(sig_c), .cmd_blk(blk_c), .meas(meas), .do_monitor(do_m),
    .signal_monitor(sig_m), .block_in(blk_m));
  bfp_core #(.TICK_CYCLES(TK)) u_dut (.sys_clk(sys_clk), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .meas(meas),
    .do_monitor(do_m), .signal_monitor(sig_m), .block_in(blk_m),
    .start_out(start_out), .retrip_out(retrip_out),
    .breaker_failure_output(bf_out), .blocked_out(blocked_out),
    .condition_code(condition_code), .behaviour_code(behaviour_code),
    .event_out(event_out));

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen %h want %h", $time, seen, want);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // Read note goes on the queue; the watcher compares it
  task automatic rd(input logic [7:0] a, input logic [31:0] w,
                    input logic [31:0] m);
    exp_q.push_back(w);
    msk_q.push_back(m);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
  endtask

  task automatic ticks(input int n);
    repeat (n * TK) @(posedge sys_clk);
  endtask

  // Bounded wait; settles past the edge before looking
  task automatic wait_hi(ref logic s, output int n);
    n = 0;
    while (s !== 1'b1 && n < 3000) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
  endtask

  function automatic logic [31:0] st(input logic [2:0] b,
                                     input logic [2:0] c, input logic [3:0] f);
    return {21'h0, b, 1'b0, c, f};
  endfunction

  // Watcher: read data stands one cycle after the strobe
  always @(posedge sys_clk) begin
    rd_d <= reg_rd;
    if (rd_d) chk(reg_rdata & msk_q.pop_front(), exp_q.pop_front());
    if (event_out.valid === 1'b1) last_ev <= event_out;
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fail_count++;
      conclude();
    end
  end

  initial begin
    seed = 32'h0ad6535f;
    {fail_count, samples_checked} = '0;
    {rst_b, reg_wr, reg_rd, do_c, sig_c, blk_c} = '0;
    reg_addr = '0;
    reg_wdata = '0;
    m_c = '0;
    last_ev = '0;
    repeat (5) @(posedge sys_clk);
    rst_b <= 1'b1;
    rd(CTRL_ADDR, 32'h1040, '1);
    rd(PHASE_THR_ADDR, 32'h14, '1);
    rd(RESID_THR_ADDR, 32'h4B0, '1);
    rd(RETRIP_DLY_ADDR, 32'h14, '1);
    rd(BF_DLY_ADDR, 32'h28, '1);
    rd(8'h18, 32'h0, '1);
    rd(STATUS_ADDR, st(1, 0, 0), 32'hFFF);
    // Shortened delays; failure kept above retrip
    wr(RETRIP_DLY_ADDR, 32'h2);
    wr(BF_DLY_ADDR, 32'h4);
    m_c.phase1 <= 16'({$random(seed)} % 190);
    m_c.phase2 <= 16'd201;
    wait_hi(start_out, k);
    wait_hi(retrip_out, k);
    chk(32'(k), 32'(2 * TK));
    wait_hi(bf_out, k);
    chk(32'(k), 32'(2 * TK));
    chk(32'(last_ev.fault_type), 32'h2);
    chk(32'(last_ev.phase2), 32'd201);
    rd(STATUS_ADDR, st(1, 3, 4'h7), 32'hFFF);
    // Between 97 % and threshold the pick-up holds
    m_c.phase2 <= 16'd195;
    ticks(3);
    chk(32'(start_out), 32'h1);
    m_c.phase2 <= 16'd193;
    ticks(3);
    rd(STATUS_ADDR, st(1, 0, 0), 32'hFFF);
    // Retrip disabled: failure still comes, retrip never
    wr(CTRL_ADDR, 32'h1000);
    m_c.phase3 <= 16'd300;
    wait_hi(bf_out, k);
    chk(32'(retrip_out), 32'h0);
    wr(CTRL_ADDR, 32'h1040);
    ticks(2);
    blk_c <= 1'b1;
    ticks(3);
    rd(STATUS_ADDR, st(2, 4, 4'h8), 32'hFFF);
    chk(32'(last_ev.is_block), 32'h1);
    chk(32'(last_ev.phase3), 32'd300);
    m_c <= '0;
    ticks(3);
    m_c.phase1 <= 16'd300;
    ticks(8);
    chk({start_out, retrip_out, bf_out, blocked_out}, 4'h1);
    {blk_c, m_c} <= '0;
    ticks(3);
    // Residual source decode against each live channel
    for (int r = 0; r < 4; r++) begin
      wr(CTRL_ADDR, 32'h1040 | (r << 4));
      for (int q = 1; q < 4; q++) begin
        m_c <= '0;
        ticks(3);
        if (q == 1) m_c.first_residual_input <= 16'd1300;
        if (q == 2) m_c.second_residual_input <= 16'd1300;
        if (q == 3) m_c.calculated_residual <= 16'd1300;
        ticks(3);
        chk(32'(start_out), 32'(r == q));
      end
    end
    m_c <= '0;
    // Forced status follows the select directly
    for (int f = 1; f < 5; f++) begin
      wr(CTRL_ADDR, 32'h1040 | 32'h80 | (f << 8));
      repeat (3) @(posedge sys_clk);
      chk(32'(condition_code), 32'(f));
    end
    wr(CTRL_ADDR, 32'h18C0);
    m_c.phase1 <= 16'd300;
    ticks(3);
    // Forced status 0 shows normal; the switch shows in the behaviour
    chk(32'(behaviour_code), 32'h2);
    chk(32'(blocked_out), 32'h0);
    wr(CTRL_ADDR, 32'h5040);
    ticks(3);
    chk(32'(start_out), 32'h0);
    chk(32'(behaviour_code), 32'h5);
    wr(RETRIP_DLY_ADDR, 32'd50);
    wr(BF_DLY_ADDR, 32'd90);
    // Every mode against random criteria
    for (int md = 0; md < 11; md++) begin
      wr(CTRL_ADDR, 32'h1040 | md);
      repeat (3) begin
        {cc, cd, cs} = 3'($random(seed));
        m_c.phase3 <= cc ? 16'd250 : 16'd100;
        m_c.phase1 <= 16'd0;
        do_c <= cd;
        sig_c <= cs;
        case (md)
          0: ex = cc;
          1: ex = cd;
          2: ex = cs;
          3: ex = cc & cd;
          4: ex = cc | cd;
          5: ex = cc & cs;
          7: ex = cs & cd;
          8: ex = cs | cd;
          10: ex = cc & cd & cs;
          default: ex = cc | cs;
        endcase
        ticks(3);
        chk(32'(start_out), 32'(ex));
      end
    end
    conclude();
  end
endmodule
